//--- eai_params.svh
// constants for the eeprom auto-init sequencer: offsets, field positions, timing
// assumes a 50 MHz system clock and a serial eeprom answering byte-read commands
//
// Summary of operation
// - eeprom copy begins only after the ram test has completed
// - ready stays low through the whole copy and rises when it ends
// - every word from 0x0000 to 0x7FFF is copied from the eeprom
// - each written word is read back; a mismatch is saved as an error
// - written values outside the excluded addresses are added to the stored checksum; nonzero result is failure
// - at ready the eeprom checksum is copied into ram word 0x004E
// - interrupt output rises right after ready when any load error occurred
// - load error sets checksum-error or ram-mismatch flag in master status
// - load error sets eeprom-load-failure bit in both terminal test words
// - address of first read-back mismatch goes to fail address register
// - after a failed copy all start bits, monitor enable and controller active stay zero
// - terminal one auto-starts when image bits, enable pin and parity allow
// - terminal two auto-starts when image bits, enable pin and parity allow
// - controller auto-starts on trigger bit and pin; start bit always self-clears
// - monitor auto-starts when image enable bit and run pin are high
// - lock pin high keeps pin address; low lets eeprom overwrite address fields
// - terminal start refused while its address parity is invalid
// - after load errors host start writes are accepted when conditions hold
// - words are big-endian in eeprom: upper byte at twice word address
// - checksums sum words ignoring carry, then complement and increment
// - auto-init pin is latched into master status 200ns after reset release
`ifndef EAI_PARAMS_SVH
`define EAI_PARAMS_SVH

// ----------------------------------------
// register offsets (word addresses)
// ----------------------------------------
`define EAI_REG_CFG        15'h0000
`define EAI_REG_STAT       15'h0001
`define EAI_REG_RT1_OPS    15'h0018
`define EAI_REG_RT1_BIT    15'h001E
`define EAI_REG_RT2_OPS    15'h0021
`define EAI_REG_FAIL       15'h0024
`define EAI_REG_RT2_BIT    15'h0027
`define EAI_CSUM_ADDR      15'h004E
`define EAI_LAST_ADDR      15'h7FFF

// ----------------------------------------
// field positions
// ----------------------------------------
`define EAI_CFG_RT2_START  3
`define EAI_CFG_RT1_START  4
`define EAI_CFG_RT1_EN     6
`define EAI_CFG_RT2_EN     7
`define EAI_CFG_MT_EN      8
`define EAI_CFG_BC_START   13
`define EAI_CFG_BC_TRIG    14
`define EAI_STAT_RAM_MIS   0
`define EAI_STAT_CSUM_ERR  1
`define EAI_STAT_BC_ACT    14
`define EAI_STAT_AUTO      15
`define EAI_OPS_LOCK       9
`define EAI_BIT_LOAD_FAIL  9
`define EAI_RESET_VAL      16'h0000

// ----------------------------------------
// timing and link
// ----------------------------------------
`define EAI_LATCH_NS       200
`define EAI_CLK_MHZ        50
`define EAI_LATCH_CYC      ((`EAI_LATCH_NS * `EAI_CLK_MHZ + 999) / 1000)
`define EAI_SPI_READ_CMD   8'h03
`define EAI_SCK_HALF       4

`endif

//--- eai_pkg.sv
// types shared by the eeprom auto-init sequencer
// assumes eai_params.svh supplies the numeric constants
package eai_pkg;

  typedef enum logic [11:0] {
    S_LATCH  = 12'h001,
    S_RAMTST = 12'h002,
    S_REQ    = 12'h004,
    S_WAIT   = 12'h008,
    S_WRITE  = 12'h010,
    S_READ   = 12'h020,
    S_HOLD   = 12'h040,
    S_CMP    = 12'h080,
    S_START  = 12'h100,
    S_READY  = 12'h200,
    S_POST   = 12'h400,
    S_RUN    = 12'h800
  } eai_sys_state_type;

  typedef enum logic [3:0] {
    L_IDLE  = 4'h1,
    L_SHIFT = 4'h2,
    L_HOLD  = 4'h4,
    L_END   = 4'h8
  } eai_link_state_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [14:0] addr;
    logic [15:0] wdata;
  } eai_host_req_type;

  typedef struct packed {
    logic       enable;
    logic       lock;
    logic       parity;
    logic [4:0] addr;
  } eai_rt_pins_type;

endpackage

//--- eai_seq.sv
// eeprom auto-init sequencer: master reset latch, eeprom copy, checks, auto-start
// assumes a synchronous word memory with one-cycle read latency and a host
// register port on the system clock; spi eeprom runs on the link clock
`include "eai_params.svh"

module eai_seq #(
  parameter int          SCK_HALF  = `EAI_SCK_HALF,
  parameter logic [14:0] LAST_ADDR = `EAI_LAST_ADDR
) (
  // clocks and reset
  input  wire logic                            i_sys_clk,
  input  wire logic                            i_rst_b,
  input  wire logic                            i_link_clk,
  // device pins
  input  wire logic                            i_auto_init_enable,
  input  wire logic                            i_controller_enable_pin,
  input  wire logic                            i_monitor_run_pin,
  input  wire eai_pkg::eai_rt_pins_type [1:0]  i_rt_pins,
  // internal status
  input  wire logic                            i_ram_test_done,
  // host register port
  input  wire eai_pkg::eai_host_req_type       i_host,
  output logic [15:0]                          o_host_rdata,
  // register and ram space
  output logic [14:0]                          o_mem_addr,
  output logic [15:0]                          o_mem_wdata,
  output logic                                 o_mem_we,
  output logic                                 o_mem_re,
  input  wire logic [15:0]                     i_mem_rdata,
  // terminal control
  output logic [15:0]                          o_master_cfg,
  output logic                                 o_bc_active,
  output logic                                 o_ready,
  output logic                                 o_irq,
  // serial eeprom
  output logic                                 o_spi_cs_b,
  output logic                                 o_spi_sck,
  output logic                                 o_spi_mosi,
  input  wire logic                            i_spi_miso
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [18:0] pin_m_r;
  logic [18:0] pin_s_r;
  always_ff @(posedge i_sys_clk)
  begin
    pin_m_r <= {i_auto_init_enable, i_controller_enable_pin, i_monitor_run_pin, i_rt_pins};
    pin_s_r <= pin_m_r;
  end

  eai_pkg::eai_rt_pins_type [1:0] rt_pin;
  logic auto_pin;
  logic bc_pin;
  logic mt_pin;
  assign {auto_pin, bc_pin, mt_pin, rt_pin} = pin_s_r;

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  eai_pkg::eai_sys_state_type state_r;
  logic [3:0]  latch_cnt_r;
  logic [14:0] addr_r;
  logic [15:0] data_r;
  logic [15:0] tally_r;
  logic [15:0] cfg_img_r;
  logic [15:0] csum_img_r;
  logic [15:0] fail_r;
  logic [15:0] fail_pend_r;
  logic        mismatch_r;
  logic        auto_r;
  logic        ram_mismatch_flag_r;
  logic        checksum_error_flag_r;
  logic        req_tgl_r;
  logic        req_last_r;
  logic        done_m_r;
  logic        done_s_r;
  logic        done_d_r;
  logic        done_tgl_r;
  logic [15:0] word_r;
  logic [1:0]  lock_r;
  logic [1:0]  rt_apf;
  logic [1:0]  rt_ok;
  logic [15:0] ops_r [2];
  logic [15:0] bit_r [2];
  logic        latch_go;
  logic        err_now;
  logic        host_run;

  assign latch_go = (state_r == eai_pkg::S_LATCH) && (latch_cnt_r == 4'(`EAI_LATCH_CYC - 1));
  assign err_now  = mismatch_r | (|tally_r);
  assign host_run = (state_r == eai_pkg::S_RUN);

  function automatic logic excluded(input logic [14:0] a);
    case (a)
      15'h0001, 15'h0002, 15'h0003, 15'h0004, 15'h0005, 15'h0007, 15'h0008,
      15'h0009, 15'h000A, 15'h000B, 15'h000C, 15'h000D, 15'h000E, 15'h0018,
      15'h001E, 15'h0021, 15'h0027, 15'h0030, 15'h0031, 15'h0035, 15'h0036,
      15'h0037, 15'h003A, 15'h003B, 15'h003C, 15'h0043, 15'h0044, 15'h0049,
      15'h004B: excluded = 1'b1;
      default:  excluded = 1'b0;
    endcase
  endfunction

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      state_r     <= eai_pkg::S_LATCH;
      latch_cnt_r <= 4'h0;
      addr_r      <= 15'h0000;
      data_r      <= 16'h0000;
      tally_r     <= 16'h0000;
      cfg_img_r   <= 16'h0000;
      csum_img_r  <= 16'h0000;
      fail_pend_r <= 16'h0000;
      mismatch_r  <= 1'b0;
      req_tgl_r   <= 1'b0;
      req_last_r  <= 1'b0;
      o_mem_addr  <= 15'h0000;
      o_mem_wdata <= 16'h0000;
      o_mem_we    <= 1'b0;
      o_mem_re    <= 1'b0;
      o_ready     <= 1'b0;
    end
    else
    begin
      o_mem_we <= 1'b0;
      o_mem_re <= 1'b0;
      case (state_r)
        eai_pkg::S_LATCH:
        begin
          latch_cnt_r <= latch_cnt_r + 4'h1;
          if (latch_go)
            state_r <= eai_pkg::S_RAMTST;
        end
        eai_pkg::S_RAMTST:
        begin
          if (i_ram_test_done)
            state_r <= auto_r ? eai_pkg::S_REQ : eai_pkg::S_READY;
        end
        eai_pkg::S_REQ:
        begin
          req_tgl_r  <= ~req_tgl_r;
          req_last_r <= (addr_r == LAST_ADDR);
          state_r    <= eai_pkg::S_WAIT;
        end
        eai_pkg::S_WAIT:
        begin
          if (done_s_r ^ done_d_r)
          begin
            data_r  <= word_r;
            state_r <= eai_pkg::S_WRITE;
          end
        end
        eai_pkg::S_WRITE:
        begin
          o_mem_addr  <= addr_r;
          o_mem_wdata <= data_r;
          o_mem_we    <= 1'b1;
          if (!excluded(addr_r))
            tally_r <= tally_r + data_r;
          if (addr_r == `EAI_REG_CFG)
            cfg_img_r <= data_r;
          if (addr_r == `EAI_CSUM_ADDR)
            csum_img_r <= data_r;
          state_r <= eai_pkg::S_READ;
        end
        eai_pkg::S_READ:
        begin
          o_mem_re <= 1'b1;
          state_r  <= eai_pkg::S_HOLD;
        end
        eai_pkg::S_HOLD:
          state_r <= eai_pkg::S_CMP;
        eai_pkg::S_CMP:
        begin
          if (i_mem_rdata != data_r)
          begin
            mismatch_r <= 1'b1;
            if (!mismatch_r)
              fail_pend_r <= {1'b0, addr_r};
          end
          addr_r  <= addr_r + 15'h0001;
          state_r <= (addr_r == LAST_ADDR) ? eai_pkg::S_START : eai_pkg::S_REQ;
        end
        eai_pkg::S_START:
          state_r <= eai_pkg::S_READY;
        eai_pkg::S_READY:
        begin
          o_ready <= 1'b1;
          if (auto_r)
          begin
            o_mem_addr  <= `EAI_CSUM_ADDR;
            o_mem_wdata <= csum_img_r;
            o_mem_we    <= 1'b1;
          end
          state_r <= eai_pkg::S_POST;
        end
        eai_pkg::S_POST:
          state_r <= eai_pkg::S_RUN;
        eai_pkg::S_RUN:
          state_r <= eai_pkg::S_RUN;
        default:
          state_r <= eai_pkg::S_LATCH;
      endcase
    end
  end

  // ----------------------------------------
  // master status, fail address, interrupt
  // ----------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      auto_r  <= 1'b0;
      ram_mismatch_flag_r <= 1'b0;
      checksum_error_flag_r <= 1'b0;
      fail_r  <= `EAI_RESET_VAL;
      o_irq   <= 1'b0;
    end
    else
    begin
      if (latch_go)
        auto_r <= auto_pin;
      if (state_r == eai_pkg::S_POST && err_now)
      begin
        o_irq   <= 1'b1;
        ram_mismatch_flag_r <= mismatch_r;
        checksum_error_flag_r <= |tally_r;
        if (mismatch_r)
          fail_r <= fail_pend_r;
      end
    end
  end

  // ----------------------------------------
  // per-terminal status and test words
  // ----------------------------------------
  localparam logic [14:0] OPS_ADDR [2] = '{`EAI_REG_RT1_OPS, `EAI_REG_RT2_OPS};
  localparam logic [14:0] BIT_ADDR [2] = '{`EAI_REG_RT1_BIT, `EAI_REG_RT2_BIT};
  localparam int          ST_BIT   [2] = '{`EAI_CFG_RT1_START, `EAI_CFG_RT2_START};
  localparam int          EN_BIT   [2] = '{`EAI_CFG_RT1_EN, `EAI_CFG_RT2_EN};

  for (genvar g = 0; g < 2; g++)
  begin : g_rt
    assign rt_apf[g] = ~^ops_r[g][15:10];
    assign rt_ok[g]  = cfg_img_r[ST_BIT[g]] & cfg_img_r[EN_BIT[g]] & rt_pin[g].enable
                     & ~rt_apf[g];

    always_ff @(posedge i_sys_clk)
    begin
      if (!i_rst_b)
      begin
        ops_r[g]  <= `EAI_RESET_VAL;
        bit_r[g]  <= `EAI_RESET_VAL;
        lock_r[g] <= 1'b0;
      end
      else
      begin
        if (latch_go)
        begin
          ops_r[g]  <= {rt_pin[g].addr, rt_pin[g].parity, rt_pin[g].lock, 9'h000};
          lock_r[g] <= rt_pin[g].lock;
        end
        if (state_r == eai_pkg::S_WRITE && addr_r == OPS_ADDR[g] && !lock_r[g])
          ops_r[g] <= data_r;
        if (host_run && i_host.wr && i_host.addr == OPS_ADDR[g])
          ops_r[g] <= i_host.wdata;
        if (state_r == eai_pkg::S_WRITE && addr_r == BIT_ADDR[g])
          bit_r[g] <= data_r;
        if (state_r == eai_pkg::S_POST && err_now)
          bit_r[g][`EAI_BIT_LOAD_FAIL] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // master configuration and auto-start
  // ----------------------------------------
  logic [15:0] cfg_r;
  logic [15:0] cfg_nxt;

  always_comb
  begin
    cfg_nxt = i_host.wdata;
    cfg_nxt[`EAI_CFG_BC_START] = 1'b0;
    cfg_nxt[`EAI_CFG_BC_TRIG]  = 1'b0;
    cfg_nxt[`EAI_CFG_MT_EN]    = i_host.wdata[`EAI_CFG_MT_EN] & mt_pin;
    for (int k = 0; k < 2; k++)
    begin
      cfg_nxt[EN_BIT[k]] = i_host.wdata[EN_BIT[k]] & rt_pin[k].enable;
      cfg_nxt[ST_BIT[k]] = i_host.wdata[ST_BIT[k]] & cfg_nxt[EN_BIT[k]]
                         & ~rt_apf[k];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      cfg_r       <= `EAI_RESET_VAL;
      o_bc_active <= 1'b0;
    end
    else
    begin
      if (state_r == eai_pkg::S_WRITE && addr_r == `EAI_REG_CFG)
      begin
        cfg_r <= data_r;
        cfg_r[`EAI_CFG_RT1_START] <= 1'b0;
        cfg_r[`EAI_CFG_RT2_START] <= 1'b0;
        cfg_r[`EAI_CFG_MT_EN]     <= 1'b0;
        cfg_r[`EAI_CFG_BC_START]  <= 1'b0;
        cfg_r[`EAI_CFG_BC_TRIG]   <= 1'b0;
      end
      if (state_r == eai_pkg::S_START && !err_now)
      begin
        cfg_r[`EAI_CFG_RT1_START] <= rt_ok[0];
        cfg_r[`EAI_CFG_RT2_START] <= rt_ok[1];
        cfg_r[`EAI_CFG_MT_EN] <= cfg_img_r[`EAI_CFG_MT_EN] & mt_pin;
        if (cfg_img_r[`EAI_CFG_BC_TRIG] && bc_pin)
          o_bc_active <= 1'b1;
      end
      if (host_run && i_host.wr && i_host.addr == `EAI_REG_CFG)
      begin
        cfg_r <= cfg_nxt;
        if (i_host.wdata[`EAI_CFG_BC_START] && bc_pin)
          o_bc_active <= 1'b1;
      end
    end
  end

  assign o_master_cfg = cfg_r;

  // ----------------------------------------
  // host read port
  // ----------------------------------------
  logic [15:0] stat_word;
  always_comb
  begin
    stat_word = 16'h0000;
    stat_word[`EAI_STAT_RAM_MIS]  = ram_mismatch_flag_r;
    stat_word[`EAI_STAT_CSUM_ERR] = checksum_error_flag_r;
    stat_word[`EAI_STAT_BC_ACT]   = o_bc_active;
    stat_word[`EAI_STAT_AUTO]     = auto_r;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      o_host_rdata <= 16'h0000;
    else if (i_host.rd)
    begin
      if (!o_ready)
        o_host_rdata <= stat_word;
      else
        case (i_host.addr)
          `EAI_REG_CFG:     o_host_rdata <= cfg_r;
          `EAI_REG_STAT:    o_host_rdata <= stat_word;
          `EAI_REG_RT1_OPS: o_host_rdata <= ops_r[0];
          `EAI_REG_RT1_BIT: o_host_rdata <= bit_r[0];
          `EAI_REG_RT2_OPS: o_host_rdata <= ops_r[1];
          `EAI_REG_FAIL:    o_host_rdata <= fail_r;
          `EAI_REG_RT2_BIT: o_host_rdata <= bit_r[1];
          default:          o_host_rdata <= 16'h0000;
        endcase
    end
  end

  // ----------------------------------------
  // link domain: spi eeprom reader
  // ----------------------------------------
  eai_pkg::eai_link_state_type lstate_r;
  logic        lrst_m_r;
  logic        lrst_s_r;
  logic        req_m_r;
  logic        req_s_r;
  logic        req_d_r;
  logic        miso_m_r;
  logic        miso_s_r;
  logic        last_r;
  logic        cmd_r;
  logic [7:0]  div_r;
  logic [4:0]  cnt_r;
  logic [23:0] sh_r;
  localparam logic [7:0] READ_CMD = `EAI_SPI_READ_CMD;

  always_ff @(posedge i_link_clk)
  begin
    lrst_m_r <= i_rst_b;
    lrst_s_r <= lrst_m_r;
    miso_m_r <= i_spi_miso;
    miso_s_r <= miso_m_r;
    req_m_r  <= req_tgl_r;
    req_s_r  <= req_m_r;
  end

  always_ff @(posedge i_link_clk)
  begin
    if (!lrst_s_r)
    begin
      lstate_r   <= eai_pkg::L_IDLE;
      req_d_r    <= 1'b0;
      done_tgl_r <= 1'b0;
      word_r     <= 16'h0000;
      last_r     <= 1'b0;
      cmd_r      <= 1'b0;
      div_r      <= 8'h00;
      cnt_r      <= 5'h00;
      sh_r       <= 24'h000000;
      o_spi_cs_b <= 1'b1;
      o_spi_sck  <= 1'b0;
      o_spi_mosi <= 1'b0;
    end
    else
    begin
      req_d_r <= req_s_r;
      case (lstate_r)
        eai_pkg::L_IDLE:
        begin
          if (req_s_r ^ req_d_r)
          begin
            o_spi_cs_b <= 1'b0;
            sh_r       <= {`EAI_SPI_READ_CMD, 16'h0000};
            o_spi_mosi <= READ_CMD[7];
            cmd_r      <= 1'b1;
            last_r     <= req_last_r;
            cnt_r      <= 5'h00;
            div_r      <= 8'h00;
            lstate_r   <= eai_pkg::L_SHIFT;
          end
        end
        eai_pkg::L_SHIFT:
        begin
          div_r <= div_r + 8'h01;
          if (div_r == 8'(SCK_HALF - 1))
          begin
            div_r <= 8'h00;
            if (!o_spi_sck)
              o_spi_sck <= 1'b1;
            else
            begin
              o_spi_sck  <= 1'b0;
              sh_r       <= {sh_r[22:0], miso_s_r};
              o_spi_mosi <= cmd_r ? sh_r[22] : 1'b0;
              cnt_r      <= cnt_r + 5'h01;
              if (cmd_r && cnt_r == 5'd23)
              begin
                cmd_r      <= 1'b0;
                cnt_r      <= 5'h00;
                o_spi_mosi <= 1'b0;
              end
              else if (!cmd_r && cnt_r == 5'd15)
              begin
                word_r     <= {sh_r[14:0], miso_s_r};
                done_tgl_r <= ~done_tgl_r;
                lstate_r   <= last_r ? eai_pkg::L_END : eai_pkg::L_HOLD;
              end
            end
          end
        end
        eai_pkg::L_HOLD:
        begin
          if (req_s_r ^ req_d_r)
          begin
            last_r   <= req_last_r;
            cnt_r    <= 5'h00;
            div_r    <= 8'h00;
            lstate_r <= eai_pkg::L_SHIFT;
          end
        end
        eai_pkg::L_END:
        begin
          o_spi_cs_b <= 1'b1;
          lstate_r   <= eai_pkg::L_IDLE;
        end
        default:
          lstate_r <= eai_pkg::L_IDLE;
      endcase
    end
  end

  // word-done event back into the system domain
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      done_m_r <= 1'b0;
      done_s_r <= 1'b0;
      done_d_r <= 1'b0;
    end
    else
    begin
      done_m_r <= done_tgl_r;
      done_s_r <= done_m_r;
      done_d_r <= done_s_r;
    end
  end

endmodule

//--- eai_seq_checker.sv
// assertions on the auto-init sequencer ports
// assumes binding to eai_seq, sys clock domain
`include "eai_params.svh"
module eai_seq_checker (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        i_ram_test_done,
  input wire logic        o_ready,
  input wire logic        o_irq,
  input wire logic        o_bc_active,
  input wire logic [15:0] o_master_cfg,
  input wire logic [14:0] o_mem_addr,
  input wire logic        o_mem_we,
  input wire logic        o_mem_re,
  input wire logic        o_spi_cs_b,
  input wire logic        o_spi_sck
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // ----
  // properties
  // ----
  sequence s_wr;
    o_mem_we && !o_ready && o_mem_addr != `EAI_CSUM_ADDR;
  endsequence
  sequence s_rb;
    o_mem_re && $stable(o_mem_addr);
  endsequence
  property p_readback;
    s_wr |=> s_rb;
  endproperty
  property p_copy_after_test;
    !o_spi_cs_b |-> i_ram_test_done;
  endproperty
  property p_ready_low;
    !o_spi_cs_b |-> !o_ready;
  endproperty
  property p_irq_after_ready;
    $rose(o_irq) |-> o_ready && $past(o_ready);
  endproperty
  property p_no_start_on_err;
    $rose(o_irq) |-> (o_master_cfg & 16'h6118) == 16'h0000 && !o_bc_active;
  endproperty
  property p_bc_bits_zero;
    !o_master_cfg[`EAI_CFG_BC_START] && !o_master_cfg[`EAI_CFG_BC_TRIG];
  endproperty
  property p_sck_idle;
    o_spi_cs_b |-> !o_spi_sck;
  endproperty
  property p_latch_wait;
    $rose(i_rst_b) |-> !o_ready [*8];
  endproperty
  a_readback: assert property (p_readback) else $error("no read-back");
  a_copy_after_test: assert property (p_copy_after_test) else $error("early copy");
  a_ready_low: assert property (p_ready_low) else $error("ready in copy");
  a_irq_after_ready: assert property (p_irq_after_ready) else $error("irq early");
  a_no_start_on_err: assert property (p_no_start_on_err) else $error("started");
  a_bc_bits_zero: assert property (p_bc_bits_zero) else $error("bc bit set");
  a_sck_idle: assert property (p_sck_idle) else $error("sck not idle");
  a_latch_wait: assert property (p_latch_wait) else $error("ready too soon");
endmodule

bind eai_seq eai_seq_checker u_chk (.i_sys_clk, .i_rst_b, .i_ram_test_done, .o_ready,
  .o_irq, .o_bc_active, .o_master_cfg, .o_mem_addr, .o_mem_we, .o_mem_re, .o_spi_cs_b,
  .o_spi_sck);

//--- eai_eeprom_model.sv
// serial eeprom partner: byte reads, sequential addressing
// assumes spi mode 0; image is mostly zero words
module eai_eeprom_model (
  input  wire logic i_cs_b,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  output logic      o_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] cmd_r = 24'h000000;
  int          cnt_r = 0;
  logic [15:0] ba;
  logic [15:0] wd;
  function automatic logic [15:0] word_at(input logic [14:0] a);
    case (a)
      15'h0000: return 16'h0150;
      15'h0018, 15'h0021: return 16'h0800;
      15'h004E: return 16'h0000 - 16'h0150;
      // terminal sums of an all-zero terminal image are zero
      15'h005C, 15'h01C0, 15'h01E0: return 16'h0000;
      default: return 16'h0000;
    endcase
  endfunction
  initial o_miso = 1'b0;
  always @(negedge i_cs_b) cnt_r = 0;
  // released line shows the inverse of the last bit
  always @(posedge i_cs_b) o_miso <= ~o_miso;
  always @(posedge i_sck)
  begin
    if (cnt_r < 24) cmd_r = {cmd_r[22:0], i_mosi};
    cnt_r++;
  end
  always @(negedge i_sck)
  begin
    if (!i_cs_b && cnt_r >= 24)
    begin
      ba = cmd_r[15:0] + 16'((cnt_r - 24) / 8);
      wd = word_at(ba[15:1]);
      o_miso <= #2 wd[(ba[0] ? 7 : 15) - (cnt_r - 24) % 8];
    end
  end
endmodule

//--- tb.sv
// self-checking bench for the auto-init sequencer
// assumes the eeprom model and a bench word memory
`include "eai_params.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [14:0] BAD = 15'h0061;
  localparam logic [14:0] LAST = 15'h007F;
  logic [14:0] bad = BAD;
  logic bc_en = 1'b1, mt_run = 1'b1;
  logic clk = 1'b0, lclk = 1'b0, rst_b = 1'b0, auto = 1'b0, rtd = 1'b0;
  logic rdy, irq, bca, cs_b, sck, mosi, miso, mwe, mre;
  logic [15:0] rdata, mwdata, cfg, d;
  logic [15:0] mrdata = 16'h0000;
  logic [14:0] maddr, top_r;
  logic [15:0] mem [0:32767];
  eai_pkg::eai_host_req_type host = '0;
  eai_pkg::eai_rt_pins_type [1:0] pins = 16'hE1C1;
  int checks = 0, mismatches = 0;
  always #10 clk = ~clk;
  always #16 lclk = ~lclk;
  always @(posedge clk)
  begin
    if (mwe) mem[maddr] <= (maddr == bad) ? ~mwdata : mwdata;
    if (mwe && maddr > top_r) top_r <= maddr;
    if (mre) mrdata <= mem[maddr];
  end
  eai_seq #(.SCK_HALF(2), .LAST_ADDR(LAST)) uut (.i_sys_clk(clk), .i_rst_b(rst_b),
    .i_link_clk(lclk), .i_auto_init_enable(auto), .i_controller_enable_pin(bc_en),
    .i_monitor_run_pin(mt_run),
    .i_rt_pins(pins), .i_ram_test_done(rtd), .i_host(host), .o_host_rdata(rdata),
    .o_mem_addr(maddr), .o_mem_wdata(mwdata), .o_mem_we(mwe), .o_mem_re(mre),
    .i_mem_rdata(mrdata), .o_master_cfg(cfg), .o_bc_active(bca), .o_ready(rdy),
    .o_irq(irq), .o_spi_cs_b(cs_b), .o_spi_sck(sck), .o_spi_mosi(mosi), .i_spi_miso(miso));
  eai_eeprom_model ee (.i_cs_b(cs_b), .i_sck(sck), .i_mosi(mosi), .o_miso(miso));
  task automatic hw(input logic [14:0] a, input logic [15:0] v);
    @(posedge clk); #1 host = {2'b10, a, v};
    @(posedge clk); #1 host = '0;
  endtask
  task automatic rd(input logic [14:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk); #1 host = {2'b01, a, 16'h0000};
    @(posedge clk); #1 host = '0;
    `CHK(rdata & m, e)
  endtask
  task automatic start(input logic a);
    @(posedge clk); #1 rst_b = 1'b0; auto = a;
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
  endtask
  task automatic wait_ready(input int lim);
    for (int i = 0; i < lim && rdy !== 1'b1; i++) @(posedge clk);
    #1 `CHK(rdy, 1'b1)
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial
  begin
    #1_500_000 mismatches++;
    report_and_stop();
  end
  initial
  begin
    start(1'b0);
    repeat (40) @(posedge clk);
    #1 `CHK(rdy, 1'b0)
    hw(`EAI_REG_CFG, 16'h0010);
    rtd = 1'b1;
    wait_ready(200);
    rd(`EAI_REG_CFG, 16'hFFFF, 16'h0000);
    hw(`EAI_REG_CFG, 16'h61D8);
    rd(`EAI_REG_CFG, 16'hFFFF, 16'h01D0);
    `CHK(bca, 1'b1)
    hw(`EAI_REG_RT2_OPS, 16'h0800);
    hw(`EAI_REG_CFG, 16'h61D8);
    rd(`EAI_REG_CFG, 16'hFFFF, 16'h01D8);
    rd(15'h0555, 16'hFFFF, 16'h0000);
    $display("manual start test done");
    top_r = '0;
    pins = 16'h8181;
    rtd = 1'b0;
    start(1'b1);
    repeat (40) @(posedge clk);
    #1 `CHK(cs_b, 1'b1)
    rtd = 1'b1;
    wait_ready(40_000);
    `CHK(top_r, LAST)
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b1)
    `CHK(mem[`EAI_CSUM_ADDR], 16'h0000 - 16'h0150)
    `CHK(ee.cmd_r, 24'h030000)
    rd(`EAI_REG_STAT, 16'h8003, 16'h8001);
    rd(`EAI_REG_FAIL, 16'h7FFF, {1'b0, BAD});
    rd(`EAI_REG_RT1_BIT, 16'h0200, 16'h0200);
    rd(`EAI_REG_RT2_BIT, 16'h0200, 16'h0200);
    rd(`EAI_REG_CFG, 16'h6118, 16'h0000);
    hw(`EAI_REG_CFG, 16'h0150);
    rd(`EAI_REG_CFG, 16'h0110, 16'h0110);
    $display("auto-init error test done");
    bad = 15'h7FFF;
    mt_run = 1'b0;
    start(1'b1);
    wait_ready(40_000);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b0)
    rd(`EAI_REG_CFG, 16'hFFFF, 16'h0050);
    rd(`EAI_REG_STAT, 16'h4003, 16'h0000);
    rd(`EAI_REG_RT2_OPS, 16'hFFFF, 16'h0800);
    $display("clean auto-init test done");
    report_and_stop();
  end
endmodule
